// [core/timer_pkg.sv]
package timer_pkg;

	// Register addresses in the processor I/O data space
	localparam logic [7:0] FLAGS_ADDR = 8'h36;
	localparam logic [7:0] CTRL_ADDR  = 8'h44;

	// Reset values
	localparam logic [7:0] FLAGS_RESET = 8'h00;
	localparam logic [7:0] CTRL_RESET  = 8'h00;

	// Flag register bit positions
	localparam int CAP_BIT  = 5;
	localparam int CMPB_BIT = 2;
	localparam int CMPA_BIT = 1;
	localparam int OVF_BIT  = 0;

	// Control register bit positions
	localparam int FORCE_BIT = 7;
	localparam int WAVE0_BIT = 6;
	localparam int COM_HI    = 5;
	localparam int COM_LO    = 4;
	localparam int WAVE1_BIT = 3;
	localparam int CS_HI     = 2;
	localparam int CS_LO     = 0;

	// Clock select encodings
	localparam logic [2:0] CS_STOP     = 3'h0;
	localparam logic [2:0] CS_DIRECT   = 3'h1;
	localparam logic [2:0] CS_DIV8     = 3'h2;
	localparam logic [2:0] CS_DIV64    = 3'h3;
	localparam logic [2:0] CS_DIV256   = 3'h4;
	localparam logic [2:0] CS_DIV1024  = 3'h5;
	localparam logic [2:0] CS_EXT_FALL = 3'h6;
	localparam logic [2:0] CS_EXT_RISE = 3'h7;

	// Prescaler width and tap masks (tick when masked bits are all ones)
	localparam int         PRE_WIDTH    = 10;
	localparam logic [9:0] DIV8_MASK    = 10'h007;
	localparam logic [9:0] DIV64_MASK   = 10'h03f;
	localparam logic [9:0] DIV256_MASK  = 10'h0ff;
	localparam logic [9:0] DIV1024_MASK = 10'h3ff;
	localparam logic [9:0] PRE_RESET    = 10'h000;

	// Second counter waveform mode sets, one bit per mode number
	localparam logic [15:0] T1_ICR_TOP_MASK    = 16'h5500;
	localparam logic [15:0] T1_OVF_MAX_MASK    = 16'h1011;
	localparam logic [15:0] T1_OVF_TOP_MASK    = 16'hc0e0;
	localparam logic [15:0] T1_OVF_BOTTOM_MASK = 16'h0f0e;

	// Number of external count pins
	localparam int EXT_PINS = 2;

	// First counter waveform modes, index is {bit one, bit zero}
	typedef enum logic [1:0] {
		WAVE_NORMAL    = 2'h0,
		WAVE_PHASE_PWM = 2'h1,
		WAVE_CTC       = 2'h2,
		WAVE_FAST_PWM  = 2'h3
	} wave_mode_t;

	// Events from the second counter datapath, same clock
	typedef struct packed {
		logic capture_event;
		logic match_a;
		logic match_b;
		logic wrapped;
		logic at_top;
		logic at_bottom;
	} t1_events_t;

	// Flag set, also used for vector acknowledges
	typedef struct packed {
		logic capture_flag;
		logic compare_b_flag;
		logic compare_a_flag;
		logic overflow_flag;
	} t1_flags_t;

	// Prescaler tap ticks
	typedef struct packed {
		logic div8;
		logic div64;
		logic div256;
		logic div1024;
	} taps_t;

	typedef struct packed {
		logic [9:0] count;
	} prescale_state_t;

	typedef struct packed {
		logic meta;
		logic stable;
		logic last;
	} sync_state_t;

	typedef struct packed {
		t1_flags_t  flags;
		logic       pend_a;
		logic       pend_b;
		logic       force_compare;
		wave_mode_t wave;
		logic [1:0] compare_output_mode;
		logic [2:0] clock_select;
		logic       t0_count_en;
		logic       t1_count_en;
		logic [7:0] rdata;
	} top_state_t;

endpackage

// [core/shared_prescaler.sv]
`timescale 1ns/100ps

module shared_prescaler (
	input  wire logic            mclk,
	input  wire logic            rstn,
	input  wire logic            restart,
	output timer_pkg::taps_t     taps
);

	timer_pkg::prescale_state_t state_ff;
	timer_pkg::prescale_state_t nxt_state;

	// Free-running count; a restart clears it for every user
	always_comb begin
		nxt_state = state_ff;
		if (restart) begin
			nxt_state.count = timer_pkg::PRE_RESET;
		end else begin
			nxt_state.count = state_ff.count + 10'h001;
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			state_ff.count <= timer_pkg::PRE_RESET;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// Taps fire once per divided period
	assign taps.div8    = (state_ff.count & timer_pkg::DIV8_MASK) == timer_pkg::DIV8_MASK;
	assign taps.div64   = (state_ff.count & timer_pkg::DIV64_MASK) == timer_pkg::DIV64_MASK;
	assign taps.div256  = (state_ff.count & timer_pkg::DIV256_MASK) == timer_pkg::DIV256_MASK;
	assign taps.div1024 = (state_ff.count & timer_pkg::DIV1024_MASK) == timer_pkg::DIV1024_MASK;

endmodule

// [core/pin_edge_detect.sv]
`timescale 1ns/100ps

module pin_edge_detect (
	input  wire logic mclk,
	input  wire logic rstn,
	input  wire logic pin,
	output logic      rise,
	output logic      fall
);

	timer_pkg::sync_state_t state_ff;
	timer_pkg::sync_state_t nxt_state;

	// Two-stage synchroniser followed by an edge history stage
	always_comb begin
		nxt_state        = state_ff;
		nxt_state.meta   = pin;
		nxt_state.stable = state_ff.meta;
		nxt_state.last   = state_ff.stable;
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			state_ff <= '0;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// Edges seen only on synchronised samples
	assign rise = state_ff.stable & ~state_ff.last;
	assign fall = ~state_ff.stable & state_ff.last;

endmodule

// [core/timer_prescaler_and_flags.sv]
// Overview of operation
// - Flags: capture b5, B b2, A b1, overflow b0
// - Other modes: capture event sets capture flag
// - Capture-top modes: top sets capture flag
// - Vector or written one clears flag
// - Compare flag set one tick after match
// - Forced compare never sets compare flags
// - Normal and CLEAR_ON_COMPARE_MODE: overflow sets overflow flag
// - One prescaler, separate clock selects per counter
// - Select 1 counts every system clock
// - Prescaler taps divide by 8,64,256,1024
// - Prescaler free running, first count 1..N+1
// - Prescaler restart affects both counters
// - External pin synchronised, edge per select 6/7
// - Pin edge reaches counter enable in 2-3 cycles
// - External edges are never divided
// - Control: force b7, wave0 b6, com b5:4, wave1 b3, cs b2:0
// - Force strobe acts only in non-PWM modes
// - Force strobe pulses a compare match out
// - Force: no interrupt, no clear, reads zero
// - Select codes: stop, direct clock, divided taps, external edges
// - Wave bits: normal, phase PWM, CLEAR_ON_COMPARE_MODE, fast PWM
`timescale 1ns/100ps

module timer_prescaler_and_flags (
	input  wire logic                  mclk,
	input  wire logic                  rstn,
	input  wire logic [7:0]            io_addr,
	input  wire logic [7:0]            io_wdata,
	input  wire logic                  io_wr,
	input  wire logic                  io_rd,
	output logic [7:0]                 io_rdata,
	input  wire logic                  ext_count_pin_zero,
	input  wire logic                  ext_count_pin_one,
	input  wire logic [2:0]            t1_clock_select,
	input  wire logic [3:0]            waveform_mode,
	input  wire logic                  prescaler_reset,
	input  timer_pkg::t1_events_t      t1_events,
	input  timer_pkg::t1_flags_t       vector_ack,
	output timer_pkg::t1_flags_t       timer_one_flags,
	output logic                       t0_count_en,
	output logic                       t1_count_en,
	output timer_pkg::wave_mode_t      t0_waveform,
	output logic [1:0]                 compare_output_mode,
	output logic                       force_compare
);

	timer_pkg::top_state_t state_ff;
	timer_pkg::top_state_t nxt_state;
	timer_pkg::taps_t      taps;
	logic [1:0]            pins;
	logic [1:0]            pin_rise;
	logic [1:0]            pin_fall;
	logic                  wr_flags;
	logic                  wr_ctrl;
	logic                  ovf_set;
	logic                  cap_set;
	logic                  tick1;
	logic [7:0]            flags_view;
	logic [7:0]            ctrl_view;
	logic                  new_wave0;

	// Shared prescaler for both counters
	// one shared prescaler
	shared_prescaler u_prescaler (
		.mclk    (mclk),
		.rstn    (rstn),
		.restart (prescaler_reset),
		.taps    (taps)
	);

	assign pins = {ext_count_pin_one, ext_count_pin_zero};

	// One synchroniser and edge detector per external count pin
	// pin sampled, edge detected
	genvar gi;
	generate
		for (gi = 0; gi < timer_pkg::EXT_PINS; gi++) begin : g_pin
			pin_edge_detect u_edge (
				.mclk (mclk),
				.rstn (rstn),
				.pin  (pins[gi]),
				.rise (pin_rise[gi]),
				.fall (pin_fall[gi])
			);
		end
	endgenerate

	// Count source selection for one counter
	function automatic logic pick_tick(
		input logic [2:0]       cs,
		input timer_pkg::taps_t tp,
		input logic             rise,
		input logic             fall
	);
		logic hit;
		hit = 1'b0;
		case (cs)
			timer_pkg::CS_STOP:     hit = 1'b0;
			timer_pkg::CS_DIRECT:   hit = 1'b1;
			timer_pkg::CS_DIV8:     hit = tp.div8;
			timer_pkg::CS_DIV64:    hit = tp.div64;
			timer_pkg::CS_DIV256:   hit = tp.div256;
			timer_pkg::CS_DIV1024:  hit = tp.div1024;
			timer_pkg::CS_EXT_FALL: hit = fall;
			timer_pkg::CS_EXT_RISE: hit = rise;
			default:                hit = 1'b0;
		endcase
		return hit;
	endfunction

	// Address decode of the two registers
	assign wr_flags  = io_wr && (io_addr == timer_pkg::FLAGS_ADDR);
	assign wr_ctrl   = io_wr && (io_addr == timer_pkg::CTRL_ADDR);
	assign new_wave0 = io_wdata[timer_pkg::WAVE0_BIT];
	assign tick1     = state_ff.t1_count_en;

	// Capture flag source depends on the second counter's mode
	always_comb begin
		cap_set = t1_events.capture_event;
		if (timer_pkg::T1_ICR_TOP_MASK[waveform_mode]) begin
			cap_set = tick1 & t1_events.at_top;
		end
	end

	// Overflow flag source depends on the second counter's mode
	always_comb begin
		ovf_set = 1'b0;
		if (timer_pkg::T1_OVF_MAX_MASK[waveform_mode]) begin
			ovf_set = t1_events.wrapped;
		end else if (timer_pkg::T1_OVF_TOP_MASK[waveform_mode]) begin
			ovf_set = tick1 & t1_events.at_top;
		end else if (timer_pkg::T1_OVF_BOTTOM_MASK[waveform_mode]) begin
			ovf_set = tick1 & t1_events.at_bottom;
		end
	end

	// Register views for read-back
	always_comb begin
		flags_view = timer_pkg::FLAGS_RESET;
		flags_view[timer_pkg::CAP_BIT]  = state_ff.flags.capture_flag;
		flags_view[timer_pkg::CMPB_BIT] = state_ff.flags.compare_b_flag;
		flags_view[timer_pkg::CMPA_BIT] = state_ff.flags.compare_a_flag;
		flags_view[timer_pkg::OVF_BIT]  = state_ff.flags.overflow_flag;
		ctrl_view = timer_pkg::CTRL_RESET;
		// control bit placement, force reads zero
		ctrl_view[timer_pkg::WAVE0_BIT]          = state_ff.wave[0];
		ctrl_view[timer_pkg::WAVE1_BIT]          = state_ff.wave[1];
		ctrl_view[timer_pkg::COM_HI:timer_pkg::COM_LO] = state_ff.compare_output_mode;
		ctrl_view[timer_pkg::CS_HI:timer_pkg::CS_LO]   = state_ff.clock_select;
	end

	// Next-state logic for flags, control, count enables and read data
	always_comb begin
		nxt_state = state_ff;

		if (tick1) begin
			nxt_state.pend_a = t1_events.match_a;
			nxt_state.pend_b = t1_events.match_b;
		end

		// vector ack or written one clears
		if (vector_ack.capture_flag || (wr_flags && io_wdata[timer_pkg::CAP_BIT])) begin
			nxt_state.flags.capture_flag = 1'b0;
		end
		if (vector_ack.compare_b_flag || (wr_flags && io_wdata[timer_pkg::CMPB_BIT])) begin
			nxt_state.flags.compare_b_flag = 1'b0;
		end
		if (vector_ack.compare_a_flag || (wr_flags && io_wdata[timer_pkg::CMPA_BIT])) begin
			nxt_state.flags.compare_a_flag = 1'b0;
		end
		if (vector_ack.overflow_flag || (wr_flags && io_wdata[timer_pkg::OVF_BIT])) begin
			nxt_state.flags.overflow_flag = 1'b0;
		end

		// capture event, or top in capture-top modes, sets flag; sets win over clears
		if (cap_set) begin
			nxt_state.flags.capture_flag = 1'b1;
		end
		if (tick1 && state_ff.pend_a) begin
			nxt_state.flags.compare_a_flag = 1'b1;
		end
		if (tick1 && state_ff.pend_b) begin
			nxt_state.flags.compare_b_flag = 1'b1;
		end
		if (ovf_set) begin
			nxt_state.flags.overflow_flag = 1'b1;
		end

		// Control register write
		nxt_state.force_compare = 1'b0;
		if (wr_ctrl) begin
			nxt_state.wave = timer_pkg::wave_mode_t'({io_wdata[timer_pkg::WAVE1_BIT], new_wave0});
			nxt_state.compare_output_mode = io_wdata[timer_pkg::COM_HI:timer_pkg::COM_LO];
			nxt_state.clock_select = io_wdata[timer_pkg::CS_HI:timer_pkg::CS_LO];
			nxt_state.force_compare = io_wdata[timer_pkg::FORCE_BIT] & ~new_wave0;
		end

		nxt_state.t0_count_en = pick_tick(state_ff.clock_select, taps, pin_rise[0], pin_fall[0]);
		nxt_state.t1_count_en = pick_tick(t1_clock_select, taps, pin_rise[1], pin_fall[1]);

		// Registered read data, unmapped addresses read zero
		if (io_rd) begin
			if (io_addr == timer_pkg::FLAGS_ADDR) begin
				nxt_state.rdata = flags_view;
			end else if (io_addr == timer_pkg::CTRL_ADDR) begin
				nxt_state.rdata = ctrl_view;
			end else begin
				nxt_state.rdata = 8'h00;
			end
		end
	end

	// State register
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			state_ff <= '0;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// Outputs straight from flops
	assign timer_one_flags     = state_ff.flags;
	assign t0_count_en         = state_ff.t0_count_en;
	assign t1_count_en         = state_ff.t1_count_en;
	assign t0_waveform         = state_ff.wave;
	assign compare_output_mode = state_ff.compare_output_mode;
	// strobe is not a flag and never clears the counter
	assign force_compare       = state_ff.force_compare;
	assign io_rdata            = state_ff.rdata;

endmodule

// [verification/timer_checker.sv]
`timescale 1ns/100ps

module timer_checker (
	input  wire logic             mclk,
	input  wire logic             rstn,
	input  wire logic [7:0]       io_addr,
	input  wire logic [7:0]       io_wdata,
	input  wire logic             io_wr,
	input  wire logic             io_rd,
	input  wire logic [7:0]       io_rdata,
	input  wire logic             ext_count_pin_one,
	input  wire logic [2:0]       t1_clock_select,
	input  wire logic [3:0]       waveform_mode,
	input  timer_pkg::t1_events_t t1_events,
	input  timer_pkg::t1_flags_t  vector_ack,
	input  timer_pkg::t1_flags_t  timer_one_flags,
	input  wire logic             t1_count_en,
	input  wire logic             force_compare
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);

	// Register reads and the force strobe
	AST_FLAGS_READ: assert property (io_rd && io_addr == timer_pkg::FLAGS_ADDR |=>
		io_rdata == {2'h0, $past(timer_one_flags[3]), 2'h0, $past(timer_one_flags[2:0])}) else $error("flag read");
	AST_CTRL_READ: assert property (io_rd && io_addr == timer_pkg::CTRL_ADDR |=> !io_rdata[7])
		else $error("force bit read");
	AST_FORCE_PULSE: assert property (io_wr && io_addr == timer_pkg::CTRL_ADDR && io_wdata[7] && !io_wdata[6]
		|=> force_compare ##1 !force_compare) else $error("force pulse");
	AST_FORCE_PWM: assert property (io_wr && io_addr == timer_pkg::CTRL_ADDR && io_wdata[6] |=> !force_compare)
		else $error("force in pwm");

	// Flag set and clear
	AST_CAPTURE: assert property (t1_events.capture_event && !timer_pkg::T1_ICR_TOP_MASK[waveform_mode]
		|=> timer_one_flags.capture_flag) else $error("capture flag");
	AST_CAP_TOP: assert property (timer_pkg::T1_ICR_TOP_MASK[waveform_mode] && t1_count_en && t1_events.at_top
		|=> timer_one_flags.capture_flag) else $error("capture top");
	AST_OVF_WRAP: assert property (waveform_mode inside {4'h0, 4'h4, 4'hc} && t1_events.wrapped
		|=> timer_one_flags.overflow_flag) else $error("overflow flag");
	AST_ACK_CLEAR: assert property (vector_ack.capture_flag && !t1_events.capture_event && !t1_events.at_top
		|=> !timer_one_flags.capture_flag) else $error("ack clear");

	// Count enables
	AST_DIRECT: assert property (t1_clock_select == timer_pkg::CS_DIRECT |=> t1_count_en)
		else $error("direct count");
	AST_EXT_RISE: assert property ($rose(ext_count_pin_one) && t1_clock_select == timer_pkg::CS_EXT_RISE
		|-> ##[2:3] t1_count_en) else $error("ext delay");

	// Main scenarios
	cover property (force_compare);
	cover property (timer_one_flags.capture_flag && timer_one_flags.overflow_flag);
	cover property (t1_clock_select == timer_pkg::CS_EXT_RISE && t1_count_en);
endmodule

bind timer_prescaler_and_flags timer_checker i_timer_checker (.mclk(mclk), .rstn(rstn), .io_addr(io_addr),
	.io_wdata(io_wdata), .io_wr(io_wr), .io_rd(io_rd), .io_rdata(io_rdata), .ext_count_pin_one(ext_count_pin_one),
	.t1_clock_select(t1_clock_select), .waveform_mode(waveform_mode), .t1_events(t1_events),
	.vector_ack(vector_ack), .timer_one_flags(timer_one_flags), .t1_count_en(t1_count_en),
	.force_compare(force_compare));

// [verification/ext_clock_source.sv]
`timescale 1ns/100ps

module ext_clock_source (
	input  wire logic mclk,
	input  wire logic run,
	output logic      pin_zero,
	output logic      pin_one
);
	int cnt = 0;

	initial begin
		pin_zero = 1'b0;
		pin_one = 1'b0;
	end

	// half period three cycles
	// Pins stand still while run is low, edges land mid-cycle
	always begin
		@(posedge mclk);
		if (run) begin
			cnt = cnt + 1;
			if (cnt == 3) begin
				cnt = 0;
				#3;
				pin_zero = ~pin_zero;
				pin_one = ~pin_one;
			end
		end
	end
endmodule

// [verification/timer_prescaler_and_flags_tb.sv]
`timescale 1ns/100ps

module timer_prescaler_and_flags_tb;
	logic                  mclk, rstn, io_wr, io_rd, prescaler_reset, run;
	logic [7:0]            io_addr, io_wdata, io_rdata;
	logic [2:0]            t1_clock_select;
	logic [3:0]            waveform_mode;
	logic                  ext_count_pin_zero, ext_count_pin_one, t0_count_en, t1_count_en, force_compare;
	logic [1:0]            compare_output_mode;
	timer_pkg::t1_events_t t1_events;
	timer_pkg::t1_flags_t  vector_ack, timer_one_flags;
	timer_pkg::wave_mode_t t0_waveform;
	int                    failures, tests_run, cycles, c0, c1, k;
	int                    dv[6] = '{0, 2048, 256, 32, 8, 2};
	logic [3:0]            mt[3] = '{4'he, 4'h1, 4'hd};
	logic [5:0]            et[3] = '{6'h02, 6'h01, 6'h07};
	logic [3:0]            xt[3] = '{4'h9, 4'h1, 4'h0};

	timer_prescaler_and_flags i_timer_prescaler_and_flags (.mclk(mclk), .rstn(rstn), .io_addr(io_addr),
		.io_wdata(io_wdata), .io_wr(io_wr), .io_rd(io_rd), .io_rdata(io_rdata),
		.ext_count_pin_zero(ext_count_pin_zero), .ext_count_pin_one(ext_count_pin_one),
		.t1_clock_select(t1_clock_select), .waveform_mode(waveform_mode), .prescaler_reset(prescaler_reset),
		.t1_events(t1_events), .vector_ack(vector_ack), .timer_one_flags(timer_one_flags),
		.t0_count_en(t0_count_en), .t1_count_en(t1_count_en), .t0_waveform(t0_waveform),
		.compare_output_mode(compare_output_mode), .force_compare(force_compare));

	ext_clock_source i_ext_clock_source (.mclk(mclk), .run(run), .pin_zero(ext_count_pin_zero),
		.pin_one(ext_count_pin_one));

	// Clock and hang guard
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 30000) begin
			failures++;
			$display("[ERR] timeout");
			wrap_up();
		end
	end

	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		io_addr <= a;
		io_wdata <= d;
		io_wr <= 1'b1;
		@(posedge mclk);
		io_wr <= 1'b0;
	endtask

	task automatic rd_chk(input string name, input logic [7:0] a, input logic [7:0] exp);
		@(posedge mclk);
		io_addr <= a;
		io_rd <= 1'b1;
		@(posedge mclk);
		io_rd <= 1'b0;
		@(negedge mclk);
		check(name, io_rdata, exp);
	endtask

	// One cycle of datapath events and vector acknowledges
	task automatic ev(input logic [5:0] e, input logic [3:0] a);
		@(posedge mclk);
		t1_events <= e;
		vector_ack <= a;
		@(posedge mclk);
		t1_events <= '0;
		vector_ack <= '0;
	endtask

	task automatic count(input int n);
		c0 = 0;
		c1 = 0;
		repeat (n) begin
			@(negedge mclk);
			c0 += (t0_count_en === 1'b1);
			c1 += (t1_count_en === 1'b1);
		end
	endtask

	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Main sequence
	initial begin
		{rstn, io_wr, io_rd, prescaler_reset, run, io_addr, io_wdata, t1_clock_select, waveform_mode} = '0;
		t1_events = '0;
		vector_ack = '0;
		repeat (5) @(posedge mclk);
		rstn <= 1'b1;
		rd_chk("flags", timer_pkg::FLAGS_ADDR, timer_pkg::FLAGS_RESET);
		rd_chk("ctrl", timer_pkg::CTRL_ADDR, timer_pkg::CTRL_RESET);
		rd_chk("unmapped", 8'h50, 8'h00);
		for (k = 0; k < 4; k++) begin
			wr(timer_pkg::CTRL_ADDR, {1'b0, k[0], 2'h2, k[1], 3'h0});
			@(negedge mclk);
			check("wave", t0_waveform, k[1:0]);
			check("com", compare_output_mode, 2'h2);
		end
		wr(timer_pkg::CTRL_ADDR, 8'h3d);
		rd_chk("ctrl_rb", timer_pkg::CTRL_ADDR, 8'h3d);
		wr(timer_pkg::CTRL_ADDR, 8'h98);
		@(negedge mclk);
		check("force", force_compare, 1'b1);
		@(negedge mclk);
		check("force_end", force_compare, 1'b0);
		rd_chk("force_rb", timer_pkg::CTRL_ADDR, 8'h18);
		wr(timer_pkg::CTRL_ADDR, 8'hc0);
		@(negedge mclk);
		check("force_pwm", force_compare, 1'b0);
		$display("test control done");
		ev(6'h20, 4'h0);
		ev(6'h04, 4'h0);
		rd_chk("set", timer_pkg::FLAGS_ADDR, 8'h21);
		wr(timer_pkg::FLAGS_ADDR, 8'h00);
		rd_chk("wr0", timer_pkg::FLAGS_ADDR, 8'h21);
		wr(timer_pkg::FLAGS_ADDR, 8'h01);
		rd_chk("wr1", timer_pkg::FLAGS_ADDR, 8'h20);
		ev(6'h00, 4'h8);
		rd_chk("ack", timer_pkg::FLAGS_ADDR, 8'h00);
		t1_clock_select <= timer_pkg::CS_DIRECT;
		repeat (3) @(posedge mclk);
		ev(6'h18, 4'h0);
		@(negedge mclk);
		check("cmp_early", timer_one_flags, 4'h0);
		repeat (2) @(negedge mclk);
		check("cmp", timer_one_flags, 4'h6);
		for (k = 0; k < 3; k++) begin
			wr(timer_pkg::FLAGS_ADDR, 8'h27);
			waveform_mode <= mt[k];
			ev(et[k], 4'h0);
			@(negedge mclk);
			check("mode_flags", timer_one_flags, xt[k]);
		end
		$display("test flags done");
		for (k = 0; k < 6; k++) begin
			wr(timer_pkg::CTRL_ADDR, {5'h0, k[2:0]});
			t1_clock_select <= 3'(5 - k);
			repeat (4) @(negedge mclk);
			count(2048);
			check("t0_rate", c0, dv[k]);
			check("t1_rate", c1, dv[5 - k]);
		end
		wr(timer_pkg::CTRL_ADDR, {5'h0, timer_pkg::CS_DIV8});
		t1_clock_select <= timer_pkg::CS_DIV8;
		repeat (5) @(posedge mclk);
		prescaler_reset <= 1'b1;
		@(posedge mclk);
		prescaler_reset <= 1'b0;
		// Skip the enable launched from the count before the restart
		@(negedge mclk);
		k = 0;
		do begin
			@(negedge mclk);
			k++;
		end while (t1_count_en !== 1'b1 && k < 20);
		check("pre_both", t0_count_en, 1'b1);
		check("pre_first", k, 16'h0008);
		$display("test prescaler done");
		// selects change while the pins stand still
		wr(timer_pkg::CTRL_ADDR, {5'h0, timer_pkg::CS_EXT_FALL});
		t1_clock_select <= timer_pkg::CS_EXT_RISE;
		repeat (3) @(posedge mclk);
		run <= 1'b1;
		repeat (12) @(negedge mclk);
		count(60);
		check("ext_fall", c0, 16'h000a);
		check("ext_rise", c1, 16'h000a);
		run <= 1'b0;
		$display("test external done");
		wrap_up();
	end
endmodule
